// >>> flt_consts.svh
// Function
// R1: Hysteresis is a five-bit unsigned field, one degree per step, up to 31.
// R2: Table pairs hold temperature at the lower address, duty at the next.
// R3: Low-resolution temperature: top bit unused, reads zero, whole degrees 0-127.
// R4: High-resolution temperature: top bit is a half degree, range 0-127.5.
// R5: Compare uses nine temperature bits in high, eight in low resolution.
// R6: Temperature above the entry limit drives the entry duty to the fan.
// R7: Limits are positive only; the sign is always taken as zero.
// R8: Limits above the native maximum come only from adding the table offset.
// R9: Low-resolution duty: two upper bits unused, read zero, six bits used.
// R10: High-resolution duty: upper two bits join lower six into eight bits.
// R11: Extended duty bits act only while the 22.5 kHz frequency is chosen.
// R12: Six-bit duty field gives the fan value in low-resolution duty mode.
// R13: Table offset is six-bit unsigned whole degrees, up to 63, added to limits.
// R14: Table entry writes need the write-enable bit; reads always allowed.
// R15: Entry duty holds until temperature drops below limit by the hysteresis.
// R16: Highest exceeded limit wins; with none exceeded the minimum duty is used.
`ifndef FLT_CONSTS_SVH
`define FLT_CONSTS_SVH

`define FLT_ADDR_W        8
`define FLT_DATA_W        8
`define FLT_TEMP_W        11
`define FLT_CMP_W         10
`define FLT_HYST_W        5
`define FLT_OFFS_W        6

`define FLT_ADDR_OFFSET   8'h4e
`define FLT_ADDR_HYST     8'h4f
`define FLT_ADDR_E1_TEMP  8'h50
`define FLT_ADDR_E1_DUTY  8'h51

`define FLT_RST_OFFSET    6'h00
`define FLT_RST_HYST      5'h04
`define FLT_RST_E1_TEMP   8'h7f
`define FLT_RST_E1_DUTY   8'h3f
`define FLT_RST_DUTY_OUT  8'h00
`define FLT_RDATA_NONE    8'h00

`define FLT_TEMP_HALF_BIT 7
`define FLT_TEMP_INT_HI   6
`define FLT_DUTY_EXT_HI   7
`define FLT_DUTY_EXT_LO   6
`define FLT_DUTY_BASE_HI  5

`endif

// >>> flt_pkg.sv
package flt_pkg;

    typedef enum logic {
        FLT_RES_LOW,
        FLT_RES_HIGH
    } flt_res_t;

endpackage

// >>> flt_entry_cmp.sv
`timescale 1ns/1ps
`include "flt_consts.svh"

module flt_entry_cmp (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [`FLT_CMP_W-1:0] temp_half,
    input  wire logic [`FLT_CMP_W-1:0] limit_half,
    input  wire logic [`FLT_HYST_W:0]  hyst_half,
    output logic                       active
);

    logic                active_r;
    logic                active_nxt;
    logic [`FLT_CMP_W:0] temp_plus_hyst;

    always_comb begin
        temp_plus_hyst = {1'b0, temp_half} +
                         {{(`FLT_CMP_W - `FLT_HYST_W){1'b0}}, hyst_half};
        active_nxt = active_r;
        if (!active_r) begin
            if (temp_half > limit_half) begin
                active_nxt = 1'b1; // R6
            end
        end else begin
            // Release once temperature sits the full hysteresis below limit.
            if (temp_plus_hyst <= {1'b0, limit_half}) begin
                active_nxt = 1'b0; // R15
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            active_r <= 1'b0;
        end else begin
            active_r <= active_nxt;
        end
    end

    assign active = active_r;

endmodule

// >>> flt_lut_entry.sv
`timescale 1ns/1ps
`include "flt_consts.svh"

module flt_lut_entry (
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic [`FLT_ADDR_W-1:0] reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic [`FLT_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_rd,
    output logic      [`FLT_DATA_W-1:0] reg_rdata,
    input  wire logic                   tbl_write_en,
    input  wire logic                   temp_hires,
    input  wire logic                   duty_hires,
    input  wire logic                   pwm_22k5_sel,
    input  wire logic [`FLT_DATA_W-1:0] min_duty,
    input  wire logic [`FLT_TEMP_W-1:0] remote_temp,
    output logic      [`FLT_DATA_W-1:0] fan_duty,
    output logic                        entry_active
);

    flt_pkg::flt_res_t temp_mode;
    flt_pkg::flt_res_t duty_mode;

    logic [`FLT_OFFS_W-1:0] offset_r;
    logic [`FLT_OFFS_W-1:0] offset_nxt;
    logic [`FLT_HYST_W-1:0] hyst_r;
    logic [`FLT_HYST_W-1:0] hyst_nxt;
    logic [`FLT_DATA_W-1:0] e1_temp_r;
    logic [`FLT_DATA_W-1:0] e1_temp_nxt;
    logic [`FLT_DATA_W-1:0] e1_duty_r;
    logic [`FLT_DATA_W-1:0] e1_duty_nxt;
    logic [`FLT_DATA_W-1:0] rdata_r;
    logic [`FLT_DATA_W-1:0] rdata_nxt;
    logic [`FLT_DATA_W-1:0] duty_out_r;
    logic [`FLT_DATA_W-1:0] duty_out_nxt;
    logic [`FLT_CMP_W-1:0]  temp_half;
    logic [`FLT_CMP_W-1:0]  limit_half;
    logic [`FLT_HYST_W:0]   hyst_half;
    logic                   e1_active;

    // Temperature entry as software sees it in the current mode.
    function automatic logic [`FLT_DATA_W-1:0] temp_view(
        input logic [`FLT_DATA_W-1:0] raw,
        input flt_pkg::flt_res_t      mode
    );
        logic [`FLT_DATA_W-1:0] v;
        v = raw;
        if (mode == flt_pkg::FLT_RES_LOW) begin
            v[`FLT_TEMP_HALF_BIT] = 1'b0; // R3
        end
        return v;
    endfunction

    // Duty entry as software sees it in the current mode.
    function automatic logic [`FLT_DATA_W-1:0] duty_view(
        input logic [`FLT_DATA_W-1:0] raw,
        input flt_pkg::flt_res_t      mode
    );
        logic [`FLT_DATA_W-1:0] v;
        v = raw;
        if (mode == flt_pkg::FLT_RES_LOW) begin
            v[`FLT_DUTY_EXT_HI:`FLT_DUTY_EXT_LO] = 2'h0; // R9
        end
        return v;
    endfunction

    always_comb begin
        temp_mode = temp_hires ? flt_pkg::FLT_RES_HIGH : flt_pkg::FLT_RES_LOW;
        duty_mode = duty_hires ? flt_pkg::FLT_RES_HIGH : flt_pkg::FLT_RES_LOW;
    end

    // Register writes.
    always_comb begin
        offset_nxt  = offset_r;
        hyst_nxt    = hyst_r;
        e1_temp_nxt = e1_temp_r;
        e1_duty_nxt = e1_duty_r;
        if (reg_wr) begin
            unique case (reg_addr)
                `FLT_ADDR_OFFSET: begin
                    offset_nxt = reg_wdata[`FLT_OFFS_W-1:0]; // R13
                end
                `FLT_ADDR_HYST: begin
                    hyst_nxt = reg_wdata[`FLT_HYST_W-1:0]; // R1
                end
                `FLT_ADDR_E1_TEMP: begin
                    if (tbl_write_en) begin
                        e1_temp_nxt = reg_wdata; // R14
                    end
                end
                `FLT_ADDR_E1_DUTY: begin
                    if (tbl_write_en) begin
                        e1_duty_nxt = reg_wdata; // R14
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            offset_r  <= `FLT_RST_OFFSET;
            hyst_r    <= `FLT_RST_HYST;
            e1_temp_r <= `FLT_RST_E1_TEMP;
            e1_duty_r <= `FLT_RST_E1_DUTY;
        end else begin
            offset_r  <= offset_nxt;
            hyst_r    <= hyst_nxt;
            e1_temp_r <= e1_temp_nxt;
            e1_duty_r <= e1_duty_nxt;
        end
    end

    // Register reads; unused upper bits read as zero.
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            unique case (reg_addr)
                `FLT_ADDR_OFFSET: begin
                    rdata_nxt = {2'h0, offset_r};
                end
                `FLT_ADDR_HYST: begin
                    rdata_nxt = {3'h0, hyst_r}; // R1
                end
                `FLT_ADDR_E1_TEMP: begin
                    rdata_nxt = temp_view(e1_temp_r, temp_mode); // R3
                end
                `FLT_ADDR_E1_DUTY: begin
                    rdata_nxt = duty_view(e1_duty_r, duty_mode); // R9
                end
                default: begin
                    rdata_nxt = `FLT_RDATA_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_r <= `FLT_RDATA_NONE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Both sides of the comparison are in half-degree units.
    always_comb begin
        if (temp_mode == flt_pkg::FLT_RES_HIGH) begin
            temp_half  = {1'b0, remote_temp[`FLT_TEMP_W-1:2]}; // R5
            limit_half = {2'h0, e1_temp_r[`FLT_TEMP_INT_HI:0],
                          e1_temp_r[`FLT_TEMP_HALF_BIT]}; // R4
        end else begin
            temp_half  = {1'b0, remote_temp[`FLT_TEMP_W-1:3], 1'b0}; // R5
            limit_half = {2'h0, e1_temp_r[`FLT_TEMP_INT_HI:0], 1'b0}; // R3
        end
        // Limit is unsigned; the offset is the only way above 127.5.
        limit_half = limit_half + {3'h0, offset_r, 1'b0}; // R7 R8 R13
        hyst_half  = {hyst_r, 1'b0}; // R1
    end

    flt_entry_cmp u_cmp (
        .clk        (clk),
        .rst_b      (rst_b),
        .temp_half  (temp_half),
        .limit_half (limit_half),
        .hyst_half  (hyst_half),
        .active     (e1_active)
    );

    // Fan duty selection.
    always_comb begin
        duty_out_nxt = min_duty; // R16
        if (e1_active) begin
            if (duty_mode == flt_pkg::FLT_RES_HIGH && pwm_22k5_sel) begin
                duty_out_nxt = e1_duty_r; // R10 R11
            end else begin
                duty_out_nxt = {2'h0,
                                e1_duty_r[`FLT_DUTY_BASE_HI:0]}; // R12 R11
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            duty_out_r <= `FLT_RST_DUTY_OUT;
        end else begin
            duty_out_r <= duty_out_nxt; // R6
        end
    end

    // Entry pair sits at consecutive addresses, temperature first.
    assign reg_rdata    = rdata_r; // R2
    assign fan_duty     = duty_out_r;
    assign entry_active = e1_active;

endmodule

// >>> flt_lut_entry_checker.sv
`timescale 1ns/1ps

module flt_lut_entry_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        tbl_write_en,
    input wire logic        temp_hires,
    input wire logic        duty_hires,
    input wire logic        pwm_22k5_sel,
    input wire logic [7:0]  min_duty,
    input wire logic [10:0] remote_temp,
    input wire logic [7:0]  fan_duty,
    input wire logic        entry_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_FAN_MIN: assert property (
        !entry_active |=> fan_duty == $past(min_duty))
        else $error("fan duty is not the minimum duty");
    AST_DUTY_LOW: assert property (
        entry_active && !(duty_hires && pwm_22k5_sel) |=> fan_duty[7:6] == 2'h0)
        else $error("extended duty bits used");
    AST_ACT_MAX: assert property (
        temp_hires && remote_temp[10:2] > 9'h17d |=> entry_active)
        else $error("entry inactive above highest limit");
    AST_ACT_ZERO: assert property (
        !temp_hires && remote_temp[10:3] == 8'h00 && !entry_active
        |=> !entry_active)
        else $error("entry active at zero degrees");
    AST_RD_UNMAP: assert property (
        reg_rd && !(reg_addr inside {[8'h4e:8'h51]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_HYST: assert property (
        reg_rd && reg_addr == 8'h4f |=> reg_rdata[7:5] == 3'h0)
        else $error("hysteresis upper bits not zero");
    AST_RD_TEMP: assert property (
        reg_rd && reg_addr == 8'h50 && !temp_hires |=> !reg_rdata[7])
        else $error("temperature top bit not zero");
    AST_RD_DUTY: assert property (
        reg_rd && reg_addr == 8'h51 && !duty_hires |=> reg_rdata[7:6] == 2'h0)
        else $error("duty upper bits not zero");
    AST_RD_HOLD: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule

bind flt_lut_entry flt_lut_entry_checker flt_lut_entry_checker_inst (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tbl_write_en(tbl_write_en), .temp_hires(temp_hires),
    .duty_hires(duty_hires), .pwm_22k5_sel(pwm_22k5_sel),
    .min_duty(min_duty), .remote_temp(remote_temp), .fan_duty(fan_duty),
    .entry_active(entry_active));

// >>> test_flt_lut_entry.sv
`timescale 1ns/1ps

module test_flt_lut_entry;
    logic        clk, rst_b, reg_wr, reg_rd, tbl_write_en;
    logic        temp_hires, duty_hires, pwm_22k5_sel, entry_active;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, min_duty, fan_duty;
    logic [10:0] remote_temp;
    int          fails;
    int          tests_run;

    flt_lut_entry flt_lut_entry_inst (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tbl_write_en(tbl_write_en), .temp_hires(temp_hires),
        .duty_hires(duty_hires), .pwm_22k5_sel(pwm_22k5_sel),
        .min_duty(min_duty), .remote_temp(remote_temp),
        .fan_duty(fan_duty), .entry_active(entry_active));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task give_verdict;
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task mode(input logic th, input logic dh, input logic pw, input logic we);
        @(posedge clk);
        temp_hires <= th;
        duty_hires <= dh;
        pwm_22k5_sel <= pw;
        tbl_write_en <= we;
    endtask

    // Two cycles of fan path latency plus one of margin.
    task temp(input logic [10:0] t, input logic act, input logic [7:0] duty);
        @(posedge clk);
        remote_temp <= t;
        repeat (3) @(posedge clk);
        #1 chk({7'h00, entry_active}, {7'h00, act});
        chk(fan_duty, duty);
    endtask

    task t_regs;
        rd(8'h4e, 8'h00);
        rd(8'h4f, 8'h04);
        rd(8'h50, 8'h7f);
        rd(8'h51, 8'h3f);
        wr(8'h50, 8'h11);
        rd(8'h50, 8'h7f);
        mode(1'b0, 1'b0, 1'b0, 1'b1);
        wr(8'h50, 8'hb2);
        wr(8'h51, 8'hc5);
        wr(8'h4f, 8'hff);
        wr(8'h4e, 8'hff);
        wr(8'h60, 8'hff);
        rd(8'h4f, 8'h1f);
        rd(8'h4e, 8'h3f);
        rd(8'h60, 8'h00);
        rd(8'h50, 8'h32);
        rd(8'h51, 8'h05);
        mode(1'b1, 1'b1, 1'b0, 1'b1);
        rd(8'h50, 8'hb2);
        rd(8'h51, 8'hc5);
    endtask

    task t_fan;
        mode(1'b0, 1'b0, 1'b0, 1'b1);
        wr(8'h4e, 8'h00);
        wr(8'h4f, 8'h05);
        wr(8'h50, 8'h32);
        temp(11'd400, 1'b0, 8'h10);
        temp(11'd408, 1'b1, 8'h05);
        mode(1'b0, 1'b1, 1'b1, 1'b1);
        temp(11'd408, 1'b1, 8'hc5);
        mode(1'b0, 1'b1, 1'b0, 1'b1);
        temp(11'd408, 1'b1, 8'h05);
        temp(11'd368, 1'b1, 8'h05);
        temp(11'd360, 1'b0, 8'h10);
        wr(8'h4e, 8'h0a);
        temp(11'd440, 1'b0, 8'h10);
        temp(11'd488, 1'b1, 8'h05);
    endtask

    task t_hires;
        wr(8'h4e, 8'h00);
        wr(8'h50, 8'hb2);
        mode(1'b1, 1'b0, 1'b0, 1'b1);
        temp(11'd360, 1'b0, 8'h10);
        temp(11'd406, 1'b0, 8'h10);
        temp(11'd408, 1'b1, 8'h05);
        temp(11'h7ff, 1'b1, 8'h05);
        temp(11'd0, 1'b0, 8'h10);
        wr(8'h50, 8'h32);
        temp(11'd407, 1'b1, 8'h05);
        mode(1'b0, 1'b0, 1'b0, 1'b1);
        temp(11'd0, 1'b0, 8'h10);
        temp(11'd407, 1'b0, 8'h10);
    endtask

    initial begin
        fails = 0;
        tests_run = 0;
        rst_b = 1'b0;
        {reg_wr, reg_rd, tbl_write_en} = 3'h0;
        {temp_hires, duty_hires, pwm_22k5_sel} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        min_duty = 8'h10;
        remote_temp = 11'h000;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_regs;
        t_fan;
        t_hires;
        give_verdict;
    end

    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        give_verdict;
    end
endmodule
